// ==== cvrt_defines.svh ====
// Register offsets, field positions and reset values of the converter result block
`ifndef CVRT_DEFINES_SVH
`define CVRT_DEFINES_SVH

`define CVRT_ADDR_W        4
`define CVRT_A_LOW         4'h0
`define CVRT_A_HIGH        4'h1
`define CVRT_A_CTLB        4'h2
`define CVRT_A_GATE        4'h3
`define CVRT_A_CTL         4'h4
`define CVRT_A_STATUS      4'h5
`define CVRT_A_MASK        4'h6

`define CVRT_CTL_EN        0
`define CVRT_CTL_AUTO      1
`define CVRT_CTL_LEFT      2
`define CVRT_CTL_START     3
`define CVRT_CTLB_CMP      6
`define CVRT_ST_DONE       0
`define CVRT_ST_OVR        1

`define CVRT_RES_W         10
`define CVRT_PIN_W         6
`define CVRT_EV_W          2
`define CVRT_RST_RESULT    10'h000
`define CVRT_RST_GATE      6'h00
`define CVRT_RST_BUF_EN    6'h3F
`define CVRT_RST_BYTE      8'h00
`define CVRT_RST_EV        2'h0

`endif

// ==== cvrt_pkg.sv ====
// Types of the converter result and trigger block
`include "cvrt_defines.svh"
package cvrt_pkg;

    typedef enum logic [2:0] {
        CVRT_TRIG_FREE    = 3'b000,
        CVRT_TRIG_CMP     = 3'b001,
        CVRT_TRIG_EXT0    = 3'b010,
        CVRT_TRIG_T0_CMPA = 3'b011,
        CVRT_TRIG_T0_OVF  = 3'b100,
        CVRT_TRIG_T1_CMPB = 3'b101,
        CVRT_TRIG_T1_OVF  = 3'b110,
        CVRT_TRIG_T1_CAP  = 3'b111
    } cvrt_trig_e;

    typedef struct packed {
        logic [`CVRT_RES_W-1:0] result;
        logic                   lock;
        logic                   left;
        logic                   en;
        logic                   auto_en;
        logic                   busy;
        cvrt_trig_e             sel;
        logic                   cmp_mux;
        logic [`CVRT_PIN_W-1:0] gate;
        logic [`CVRT_EV_W-1:0]  status;
        logic [`CVRT_EV_W-1:0]  mask;
        logic                   trig_prev;
        logic [`CVRT_PIN_W-1:0] sync1;
        logic [`CVRT_PIN_W-1:0] sync2;
        logic [`CVRT_PIN_W-1:0] pin_value;
        logic [`CVRT_PIN_W-1:0] buf_en;
        logic [7:0]             rd_data;
        logic                   conv_start;
        logic                   irq;
    } cvrt_state_s;

endpackage

// ==== cvrt_top.sv ====
// Result presentation, read interlock, auto trigger and pin input gating of the converter
`timescale 1ns/1ns
`default_nettype none
`include "cvrt_defines.svh"

module cvrt_top (
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire logic [`CVRT_ADDR_W-1:0] addr,
    input  wire logic [7:0]              wr_data,
    input  wire logic                    wr_en,
    input  wire logic                    rd_en,
    output var  logic [7:0]              rd_data,
    input  wire logic                    conv_done,
    input  wire logic [`CVRT_RES_W-1:0]  conv_result,
    input  wire logic [7:1]              trig_flags,
    output var  logic                    conv_start,
    input  wire logic [`CVRT_PIN_W-1:0]  pin_raw,
    output var  logic [`CVRT_PIN_W-1:0]  pin_value,
    output var  logic [`CVRT_PIN_W-1:0]  pin_buf_en,
    output var  logic                    comparator_mux_enable,
    output var  logic                    irq
);
    import cvrt_pkg::*;

    localparam cvrt_state_s RST = '{
        result:     `CVRT_RST_RESULT,
        lock:       1'b0,
        left:       1'b0,
        en:         1'b0,
        auto_en:    1'b0,
        busy:       1'b0,
        sel:        CVRT_TRIG_FREE,
        cmp_mux:    1'b0,
        gate:       `CVRT_RST_GATE,
        status:     `CVRT_RST_EV,
        mask:       `CVRT_RST_EV,
        trig_prev:  1'b0,
        sync1:      `CVRT_RST_GATE,
        sync2:      `CVRT_RST_GATE,
        pin_value:  `CVRT_RST_GATE,
        buf_en:     `CVRT_RST_BUF_EN,
        rd_data:    `CVRT_RST_BYTE,
        conv_start: 1'b0,
        irq:        1'b0
    };

    cvrt_state_s r;
    cvrt_state_s next_r;

    logic                 lo_rd;
    logic                 hi_rd;
    logic                 ctl_wr;
    logic                 sw_start;
    logic                 en_now;
    logic                 trig_sig;
    logic                 trig_edge;
    logic                 upd;
    logic                 idle;
    logic                 free_restart;
    logic                 start;
    logic [`CVRT_EV_W-1:0] ev_set;
    logic [`CVRT_EV_W-1:0] ev_clr;
    logic [`CVRT_PIN_W-1:0] pin_gated;
    logic                 ref_flag;

    // Byte view of the held result, chosen live from the adjust bit
    function automatic logic [7:0] fmt_byte(input logic [`CVRT_RES_W-1:0] res,
                                            input logic                    left,
                                            input logic                    high);
        logic [7:0] b;
        if (left) begin
            b = high ? res[9:2] : {res[1:0], 6'h00};
        end else begin
            b = high ? {6'h00, res[9:8]} : res[7:0];
        end
        return b;
    endfunction

    // Free running has no flag of its own
    function automatic logic sel_flag(input cvrt_trig_e sel, input logic [7:1] flags);
        logic f;
        f = 1'b0;
        if (sel != CVRT_TRIG_FREE) begin
            f = flags[sel];
        end
        return f;
    endfunction

    assign lo_rd    = rd_en && (addr == `CVRT_A_LOW);
    assign hi_rd    = rd_en && (addr == `CVRT_A_HIGH);
    assign ctl_wr   = wr_en && (addr == `CVRT_A_CTL);
    assign sw_start = ctl_wr && wr_data[`CVRT_CTL_START];
    assign en_now   = ctl_wr ? wr_data[`CVRT_CTL_EN] : r.en;

    // Previous level follows whatever is selected, so a source switch can edge
    assign trig_sig  = sel_flag(r.sel, trig_flags);
    assign trig_edge = trig_sig & ~r.trig_prev;

    // High byte read in the same cycle releases the lock in time
    assign upd  = conv_done && (!r.lock || hi_rd);
    assign idle = !r.busy || conv_done;
    assign free_restart = conv_done && r.auto_en && (r.sel == CVRT_TRIG_FREE);
    // Triggers during a conversion are dropped, not queued
    assign start = en_now && idle
        && (sw_start || (r.auto_en && trig_edge) || free_restart);

    assign ev_set = {conv_done & ~upd, upd};
    assign ev_clr = (wr_en && addr == `CVRT_A_STATUS) ? wr_data[`CVRT_EV_W-1:0] : `CVRT_RST_EV;

    // One gate per analog pin; channels 6 and 7 carry no gate bit
    for (genvar p = 0; p < `CVRT_PIN_W; p++) begin : g_pin
        assign pin_gated[p] = r.sync2[p] & ~r.gate[p];
    end

    always_comb begin
        next_r = r;
        next_r.conv_start = start;
        next_r.busy = start | (r.busy & ~conv_done & en_now);
        next_r.trig_prev = trig_sig;
        if (upd) begin
            next_r.result = conv_result;
        end
        if (lo_rd) begin
            next_r.lock = 1'b1;
        end else if (hi_rd) begin
            next_r.lock = 1'b0;
        end
        // Set wins over a same-cycle write-one clear
        next_r.status = (r.status & ~ev_clr) | ev_set;
        if (ctl_wr) begin
            next_r.en = wr_data[`CVRT_CTL_EN];
            next_r.auto_en = wr_data[`CVRT_CTL_AUTO];
            next_r.left = wr_data[`CVRT_CTL_LEFT];
        end
        if (wr_en && addr == `CVRT_A_CTLB) begin
            next_r.cmp_mux = wr_data[`CVRT_CTLB_CMP];
            next_r.sel = cvrt_trig_e'(wr_data[2:0]);
        end
        if (wr_en && addr == `CVRT_A_GATE) begin
            next_r.gate = wr_data[`CVRT_PIN_W-1:0];
        end
        if (wr_en && addr == `CVRT_A_MASK) begin
            next_r.mask = wr_data[`CVRT_EV_W-1:0];
        end
        next_r.irq = |(next_r.status & next_r.mask);
        next_r.sync1 = pin_raw;
        next_r.sync2 = r.sync1;
        next_r.pin_value = pin_gated;
        next_r.buf_en = ~r.gate;
        next_r.rd_data = `CVRT_RST_BYTE;
        if (rd_en) begin
            unique case (addr)
                `CVRT_A_LOW:    next_r.rd_data = fmt_byte(r.result, r.left, 1'b0);
                `CVRT_A_HIGH:   next_r.rd_data = fmt_byte(r.result, r.left, 1'b1);
                `CVRT_A_CTLB:   next_r.rd_data = {1'b0, r.cmp_mux, 3'h0, r.sel};
                `CVRT_A_GATE:   next_r.rd_data = {2'h0, r.gate};
                `CVRT_A_CTL:    next_r.rd_data = {4'h0, r.busy, r.left, r.auto_en, r.en};
                `CVRT_A_STATUS: next_r.rd_data = {6'h00, r.status};
                `CVRT_A_MASK:   next_r.rd_data = {6'h00, r.mask};
                default:        next_r.rd_data = `CVRT_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= RST;
        end else begin
            r <= next_r;
        end
    end

    assign rd_data               = r.rd_data;
    assign conv_start            = r.conv_start;
    assign pin_value             = r.pin_value;
    assign pin_buf_en            = r.buf_en;
    assign comparator_mux_enable = r.cmp_mux;
    assign irq                   = r.irq;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_right_adjust_read: assert property (
        hi_rd && !r.left |=> rd_data == {6'h00, $past(r.result[9:8])})
        else $error("right adjusted high byte wrong");

    a_left_low_read: assert property (
        lo_rd && r.left |=> rd_data == {$past(r.result[1:0]), 6'h00})
        else $error("left adjusted low byte wrong");

    a_lock_holds_result: assert property (
        r.lock && !hi_rd |=> $stable(r.result))
        else $error("locked result changed");

    a_locked_done_overrun: assert property (
        conv_done && r.lock && !hi_rd |=> r.status[`CVRT_ST_OVR] && !r.status[`CVRT_ST_DONE]
            || $past(ev_clr[`CVRT_ST_DONE]) == 1'b0 && r.status[`CVRT_ST_OVR])
        else $error("completion under lock not reported as overrun");

    a_auto_off_quiet: assert property (
        !r.auto_en && !sw_start |=> !conv_start)
        else $error("start without software or auto trigger");

    a_edge_starts: assert property (
        en_now && r.auto_en && trig_edge && idle |=> conv_start ##1 !conv_start)
        else $error("trigger edge did not give one start pulse");

    a_switch_edge: assert property (
        r.sel != next_r.sel && !trig_sig && next_r.sel != CVRT_TRIG_FREE
            && trig_flags[next_r.sel] |=> trig_edge)
        else $error("source switch did not edge");

    a_free_no_edge: assert property (
        r.sel == CVRT_TRIG_FREE |-> !trig_edge)
        else $error("free running produced a trigger edge");

    a_trig_decode: assert property (
        r.sel != CVRT_TRIG_FREE |-> trig_sig == ref_flag)
        else $error("trigger select decode wrong");

    a_gate_forces_zero: assert property (
        ##1 (pin_value & $past(r.gate)) == 6'h00 && pin_buf_en == ~$past(r.gate))
        else $error("disabled pin not gated");

    a_gate_high_zero: assert property (
        rd_en && addr == `CVRT_A_GATE |=> rd_data[7:6] == 2'h0)
        else $error("gate bits 7:6 not zero");

    a_done_flag_set: assert property (
        upd |=> r.status[`CVRT_ST_DONE] && r.result == $past(conv_result))
        else $error("done flag or result not updated");

    a_free_restart: assert property (
        en_now && free_restart |=> conv_start)
        else $error("free running did not restart");

    a_irq_level: assert property (
        irq == |(r.status & r.mask))
        else $error("interrupt level mismatch");

    // Select table written out apart from the select function
    always_comb begin
        ref_flag = 1'b0;
        case (r.sel)
            CVRT_TRIG_FREE:    ref_flag = 1'b0;
            CVRT_TRIG_CMP:     ref_flag = trig_flags[1];
            CVRT_TRIG_EXT0:    ref_flag = trig_flags[2];
            CVRT_TRIG_T0_CMPA: ref_flag = trig_flags[3];
            CVRT_TRIG_T0_OVF:  ref_flag = trig_flags[4];
            CVRT_TRIG_T1_CMPB: ref_flag = trig_flags[5];
            CVRT_TRIG_T1_OVF:  ref_flag = trig_flags[6];
            CVRT_TRIG_T1_CAP:  ref_flag = trig_flags[7];
        endcase
    end

    a_right_low_read: assert property (
        lo_rd && !r.left |=> rd_data == $past(r.result[7:0]))
        else $error("right adjusted low byte wrong");

    a_left_high_read: assert property (
        hi_rd && r.left |=> rd_data == $past(r.result[9:2]))
        else $error("left adjusted high byte wrong");

    a_low_read_locks: assert property (
        lo_rd |=> r.lock)
        else $error("low byte read did not lock");

    a_high_read_unlocks: assert property (
        hi_rd |=> !r.lock)
        else $error("high byte read did not unlock");

    a_adjust_at_once: assert property (
        ctl_wr |=> r.left == $past(wr_data[`CVRT_CTL_LEFT]))
        else $error("left adjust not taken at once");

    a_done_sticky: assert property (
        r.status[`CVRT_ST_DONE] && !ev_clr[`CVRT_ST_DONE] |=> r.status[`CVRT_ST_DONE])
        else $error("done flag lost without clear");

    a_done_clear: assert property (
        ev_clr[`CVRT_ST_DONE] && !upd |=> !r.status[`CVRT_ST_DONE])
        else $error("done flag not cleared");

    a_busy_drop: assert property (
        r.busy && conv_done && !start |=> !r.busy)
        else $error("busy kept after completion");

    a_disabled_quiet: assert property (
        !en_now |=> !conv_start)
        else $error("start while converter disabled");

    a_status_read: assert property (
        rd_en && addr == `CVRT_A_STATUS |=> rd_data == {6'h00, $past(r.status)})
        else $error("status read wrong");

    a_mask_read: assert property (
        rd_en && addr == `CVRT_A_MASK |=> rd_data == {6'h00, $past(r.mask)})
        else $error("mask read wrong");

    a_gate_read: assert property (
        rd_en && addr == `CVRT_A_GATE |=> rd_data == {2'h0, $past(r.gate)})
        else $error("gate read wrong");

    a_ctlb_reserved: assert property (
        rd_en && addr == `CVRT_A_CTLB |=> rd_data[7] == 1'b0 && rd_data[5:3] == 3'h0)
        else $error("control B reserved bits not zero");

    a_unmapped_zero: assert property (
        rd_en && addr > `CVRT_A_MASK |=> rd_data == `CVRT_RST_BYTE)
        else $error("unmapped read not zero");

    a_rd_idle_zero: assert property (
        !rd_en |=> rd_data == `CVRT_RST_BYTE)
        else $error("read data not zero outside read");

    c_lock_release: cover property (lo_rd ##[1:4] hi_rd);
    c_auto_edge: cover property (r.auto_en && trig_edge && r.en ##1 conv_start);
    c_overrun: cover property (conv_done && r.lock && !hi_rd);
    c_free_run: cover property (free_restart && en_now ##1 conv_start);
    c_source_switch: cover property (r.sel != next_r.sel ##1 trig_edge);

endmodule

`default_nettype wire

// ==== cvrt_core_model.sv ====
// Behavioural model of the analog core that answers conversion starts
`timescale 1ns/1ns
`default_nettype none

module cvrt_core_model (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       conv_start,
    input  wire logic [9:0] value,
    input  wire logic [4:0] delay,
    output var  logic       conv_done,
    output wire logic [9:0] conv_result
);
    logic [4:0] cnt;
    logic [9:0] held;

    // Outside the done pulse the result lines show the inverted held value
    assign conv_result = conv_done ? held : ~held;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 5'h00;
            held <= 10'h000;
            conv_done <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            if (conv_start) begin
                cnt <= delay;
            end else if (cnt != 5'h00) begin
                cnt <= cnt - 5'h01;
                if (cnt == 5'h01) begin
                    conv_done <= 1'b1;
                    held <= value;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ==== tb_cvrt_top.sv ====
// Self-checking bench of the converter result and trigger block
`timescale 1ns/1ns
`default_nettype none
`include "cvrt_defines.svh"

module tb_cvrt_top;
    logic       clock;
    logic       rst_n;
    logic [3:0] addr;
    logic [7:0] wr_data;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] rd_data;
    logic       conv_done;
    logic [9:0] conv_result;
    logic [7:1] trig_flags;
    logic       conv_start;
    logic [5:0] pin_raw;
    logic [5:0] pin_value;
    logic [5:0] pin_buf_en;
    logic       comparator_mux_enable;
    logic       irq;
    logic [9:0] core_value;
    logic [4:0] core_delay;
    int         bad_count;
    int         samples_checked;
    typedef struct {logic [9:0] res; logic [7:0] ctl, lo, hi;} cvrt_row_s;
    cvrt_row_s  rows [5];

    cvrt_top u_dut (.clock, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
        .conv_done, .conv_result, .trig_flags, .conv_start, .pin_raw, .pin_value,
        .pin_buf_en, .comparator_mux_enable, .irq);
    cvrt_core_model u_core (.clock, .rst_n, .conv_start, .value(core_value),
        .delay(core_delay), .conv_done, .conv_result);

    task automatic finish_test();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic [5:0] got, input logic [5:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        chk_reg(rd_data, exp);
    endtask

    // Bounded wait on the start pulse (pick 0) or the done pulse (pick 1)
    task automatic wait_hi(input bit pick);
        int n;
        #1;
        for (n = 0; n < 300 && (pick ? conv_done : conv_start) !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        if (n == 300) begin
            bad_count++;
            finish_test();
        end
    endtask

    task automatic no_start(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clock);
            #1;
            seen = seen | conv_start;
        end
        chk_bit(6'(seen), 6'h00);
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        rows = '{'{10'h3FF, 8'h09, 8'hFF, 8'h03}, '{10'h2A5, 8'h09, 8'hA5, 8'h02},
                 '{10'h2A5, 8'h0D, 8'h40, 8'hA9}, '{10'h3FF, 8'h0D, 8'hC0, 8'hFF},
                 '{10'h001, 8'h0D, 8'h40, 8'h00}};
        rst_n = 1'b0;
        addr = 4'h0;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        trig_flags = 7'h00;
        pin_raw = 6'h00;
        core_value = 10'h000;
        core_delay = 5'h01;
        bad_count = 0;
        samples_checked = 0;
        repeat (5) @(posedge clock);
        #1;
        chk_bit(pin_buf_en, 6'h3F);
        @(posedge clock);
        rst_n <= 1'b1;
        for (int a = 0; a < 7; a++) rd(4'(a), 8'h00);
        foreach (rows[i]) begin
            core_value <= rows[i].res;
            core_delay <= i[0] ? 5'h14 : 5'h01;
            wr(`CVRT_A_CTL, rows[i].ctl);
            wait_hi(0);
            wait_hi(1);
            rd(`CVRT_A_STATUS, 8'h01);
            rd(`CVRT_A_LOW, rows[i].lo);
            rd(`CVRT_A_HIGH, rows[i].hi);
            wr(`CVRT_A_STATUS, 8'h03);
        end
        // Second conversion lands while the pair is held
        core_value <= 10'h1C6;
        wr(`CVRT_A_CTL, 8'h09);
        wait_hi(0);
        wait_hi(1);
        rd(`CVRT_A_LOW, 8'hC6);
        core_value <= 10'h2AA;
        wr(`CVRT_A_STATUS, 8'h03);
        wr(`CVRT_A_CTL, 8'h09);
        wait_hi(0);
        wait_hi(1);
        rd(`CVRT_A_STATUS, 8'h02);
        wr(`CVRT_A_CTL, 8'h05);
        rd(`CVRT_A_HIGH, 8'h71);
        rd(`CVRT_A_LOW, 8'h80);
        rd(`CVRT_A_HIGH, 8'h71);
        wr(`CVRT_A_STATUS, 8'h03);
        wr(`CVRT_A_CTL, 8'h03);
        for (int s = 1; s < 8; s++) begin
            wr(`CVRT_A_CTLB, 8'(s));
            trig_flags[s] <= 1'b1;
            wait_hi(0);
            wait_hi(1);
            trig_flags <= 7'h00;
        end
        wr(`CVRT_A_CTLB, 8'h01);
        trig_flags <= 7'h02;
        no_start(5);
        wr(`CVRT_A_CTLB, 8'h02);
        wait_hi(0);
        wait_hi(1);
        wr(`CVRT_A_CTLB, 8'h00);
        no_start(8);
        trig_flags <= 7'h00;
        wr(`CVRT_A_CTL, 8'h01);
        wr(`CVRT_A_CTLB, 8'h03);
        trig_flags <= 7'h04;
        no_start(8);
        trig_flags <= 7'h00;
        wr(`CVRT_A_CTLB, 8'h00);
        wr(`CVRT_A_CTL, 8'h0B);
        wait_hi(0);
        wait_hi(1);
        wait_hi(0);
        wait_hi(1);
        wr(`CVRT_A_CTL, 8'h00);
        no_start(30);
        wr(`CVRT_A_MASK, 8'h01);
        repeat (2) @(posedge clock);
        #1;
        chk_bit(6'(irq), 6'h01);
        wr(`CVRT_A_MASK, 8'h00);
        repeat (2) @(posedge clock);
        #1;
        chk_bit(6'(irq), 6'h00);
        wr(`CVRT_A_MASK, 8'h03);
        wr(`CVRT_A_STATUS, 8'h03);
        repeat (2) @(posedge clock);
        #1;
        chk_bit(6'(irq), 6'h00);
        // Gated pins read zero and have their input buffers turned off
        pin_raw <= 6'h3F;
        wr(`CVRT_A_GATE, 8'h15);
        repeat (4) @(posedge clock);
        #1;
        chk_bit(pin_value, 6'h2A);
        chk_bit(pin_buf_en, 6'h2A);
        rd(`CVRT_A_GATE, 8'h15);
        wr(`CVRT_A_CTLB, 8'h47);
        rd(`CVRT_A_CTLB, 8'h47);
        chk_bit(6'(comparator_mux_enable), 6'h01);
        wr(4'h7, 8'hFF);
        rd(4'h7, 8'h00);
        // Mid-run reset drops every register back
        @(posedge clock);
        rst_n <= 1'b0;
        #1;
        chk_bit(pin_buf_en, 6'h3F);
        chk_bit(6'(comparator_mux_enable), 6'h00);
        @(posedge clock);
        rst_n <= 1'b1;
        rd(`CVRT_A_CTLB, 8'h00);
        rd(`CVRT_A_GATE, 8'h00);
        finish_test();
    end
endmodule

`default_nettype wire
